// file: tb_temperature_limit_registers.sv
module tb_temperature_limit_registers import tlr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] RCMD [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h13,
    8'h14, 8'h09};
  localparam logic [7:0] RRST [7] = '{8'h3c, 8'h00, 8'h50, 8'h00, 8'h00,
    8'h00, 8'h00};
  // Local high at +16 so a -16 reading only trips it if compared unsigned
  localparam logic [7:0] ELIM [7] = '{8'h10, 8'hf6, 8'h50, 8'h05, 8'h00,
    8'h00, 8'h00};
  localparam int         DEPTH[4] = '{1, 2, 4, 6};

  logic        clk, rstn, wr, rd, conv, rvld;
  logic [7:0]  cmd, wdata, ltemp, rdata;
  logic [11:0] rtemp;
  logic [1:0]  dsel;
  logic [3:0]  ev;
  logic [7:0]  exp_q[$];
  logic [31:0] lfsr;
  int          err_total, total_checks, cyc;
  int          ev_cnt[4];

  tlr_host_model i_host (.clk_in(clk), .cmd_out(cmd), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));

  tlr_limit_bank i_dut (.clk_in(clk), .rstn_in(rstn), .cmd_in(cmd),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .conv_done_in(conv),
    .local_temp_in(ltemp), .remote_temp_in(rtemp),
    .queue_depth_select_in(dsel), .rdata_out(rdata),
    .rd_valid_out(rvld), .local_high_event_out(ev[0]),
    .local_low_event_out(ev[1]), .remote_high_event_out(ev[2]),
    .remote_low_event_out(ev[3]));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.read_reg(c);
  endtask

  // Back-to-back conversions, then settle time for the event pulse
  task automatic convert(input int n);
    if (n > 0) begin
      @(posedge clk);
      conv <= 1'b1;
      repeat (n) @(posedge clk);
      conv <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask

  // Rewriting a limit restarts its streak
  task automatic flush();
    i_host.write_reg(8'h06, ELIM[1]);
    i_host.write_reg(8'h08, ELIM[3]);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Read monitor pairs each valid strobe with the oldest note; hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_sim();
    end
    for (int k = 0; k < 4; k++) if (ev[k] === 1'b1) ev_cnt[k]++;
    if (rvld === 1'b1) begin
      check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
  end

  initial begin
    rstn  = 1'b0;
    conv  = 1'b0;
    ltemp = 8'hf0;
    rtemp = 12'h040;
    dsel  = DSEL_1;
    lfsr  = 32'h0bddf730;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // Power-up values, unmapped command reads zero
    for (int i = 0; i < 7; i++) rd_chk(RCMD[i], RRST[i]);
    // Random write then read back; fraction keeps only bits 7:4
    for (int i = 0; i < 7; i++) begin
      lfsr = lfsr_next(lfsr);
      i_host.write_reg(RCMD[i], lfsr[7:0]);
      rd_chk(RCMD[i], i == 6 ? 8'h00 : i < 4 ? lfsr[7:0]
        : lfsr[7:0] & 8'hf0);
    end
    for (int i = 0; i < 7; i++) i_host.write_reg(RCMD[i], ELIM[i]);
    // Every depth code: a broken streak must not fire, a full one once
    for (int d = 0; d < 4; d++) begin
      @(posedge clk);
      dsel <= 2'(d);
      flush();
      convert(DEPTH[d] - 1);
      flush();
      convert(DEPTH[d] - 1);
      check(8'(ev_cnt[1] + ev_cnt[3]), 8'(2 * d));
      convert(2);
      check(8'(ev_cnt[1]), 8'(d + 1));
      check(8'(ev_cnt[3]), 8'(d + 1));
      check(8'(ev_cnt[0] + ev_cnt[2]), 8'h00);
    end
    repeat (5) @(posedge clk);
    check(8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule

// file: tlr_fault_queue.sv
module tlr_fault_queue
  import tlr_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  tlr_fq_if.queue  fq
);
  import tlr_pkg::*;

  logic [CNT_W-1:0] lim;

  // Depth decode shared by every channel
  always_comb begin
    unique case (fq.depth_sel)
      DSEL_1: lim = DEPTH_1;
      DSEL_2: lim = DEPTH_2;
      DSEL_4: lim = DEPTH_4;
      DSEL_6: lim = DEPTH_6;
    endcase
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  for (genvar ch = 0; ch < N; ch++) begin : g_ch
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             ev_q;
    logic             ev_d;
    logic             hit;

    assign hit = fq.sample && fq.exceed[ch] && !fq.flush[ch];

    // Count consecutive hits; a flush beats a sample in the same cycle
    always_comb begin
      cnt_d = cnt_q;
      ev_d  = 1'b0;
      if (fq.flush[ch]) begin
        cnt_d = CNT_RST;
      end else if (fq.sample) begin
        if (!fq.exceed[ch]) begin
          cnt_d = CNT_RST;
        end else if (cnt_q < lim) begin
          cnt_d = cnt_q + 3'h1;
          ev_d  = (cnt_q + 3'h1) == lim;
        end
      end
    end

    // Saturated count keeps one event per streak
    always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
        cnt_q <= CNT_RST;
        ev_q  <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        ev_q  <= ev_d;
      end
    end

    assign fq.event_hit[ch] = ev_q;

    sequence s_six_hits;
      (hit && cnt_q == CNT_RST && fq.depth_sel == DSEL_6) ##1
      (hit && fq.depth_sel == DSEL_6)[*5];
    endsequence

    a_depth_six: assert property (s_six_hits |=> ev_q)
      else $error("six hits gave no event");
    a_depth_one: assert property (
      hit && cnt_q == CNT_RST && fq.depth_sel == DSEL_1 |=> ev_q)
      else $error("depth one hit gave no event");
    a_event_at_depth: assert property (ev_q |-> cnt_q == $past(lim))
      else $error("event before queue depth reached");
    a_flush_clears: assert property (fq.flush[ch] |=> !ev_q && cnt_q == 0)
      else $error("flush did not clear queue");
  end
endmodule

// file: tlr_fq_if.sv
// Links the limit bank to its fault queues
interface tlr_fq_if #(parameter int N = 4);
  logic [N-1:0] flush;
  logic [N-1:0] exceed;
  logic         sample;
  logic [1:0]   depth_sel;
  logic [N-1:0] event_hit;
  modport bank  (output flush, exceed, sample, depth_sel, input event_hit);
  modport queue (input flush, exceed, sample, depth_sel, output event_hit);
endinterface

// file: tlr_host_model.sv
// Register-side host: one strobe per byte, bus parked on inverted values
module tlr_host_model (
  input  wire logic       clk_in,
  output logic      [7:0] cmd_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    cmd_out   = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // Write pulse of one cycle; old data inverted so it never looks valid
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge clk_in);
    cmd_out   <= cmd;
    wdata_out <= data;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    cmd_out   <= ~cmd;
    wdata_out <= ~data;
  endtask

  // Read pulse of one cycle; data is picked up by the bench monitor
  task automatic read_reg(input logic [7:0] cmd);
    @(posedge clk_in);
    cmd_out <= cmd;
    rd_out  <= 1'b1;
    @(posedge clk_in);
    rd_out  <= 1'b0;
    cmd_out <= ~cmd;
  endtask
endmodule

// file: tlr_limit_bank.sv
module tlr_limit_bank
  import tlr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  cmd_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        conv_done_in,
  input  wire logic [7:0]  local_temp_in,
  input  wire logic [11:0] remote_temp_in,
  input  wire logic [1:0]  queue_depth_select_in,
  output logic [7:0]       rdata_out,
  output logic             rd_valid_out,
  output logic             local_high_event_out,
  output logic             local_low_event_out,
  output logic             remote_high_event_out,
  output logic             remote_low_event_out
);
  import tlr_pkg::*;

  logic [7:0]         lim_q [NUM_LIM];
  logic [7:0]         lim_d [NUM_LIM];
  logic [NUM_LIM-1:0] wr_hit;
  logic [NUM_LIM-1:0] rd_hit;
  logic [7:0]         rdata_q;
  logic [7:0]         rdata_d;
  logic               rd_valid_q;
  logic               rd_valid_d;
  logic [NUM_CH-1:0]  flush;
  logic signed [11:0] remote_temp;
  logic signed [11:0] remote_upper;
  logic signed [11:0] remote_lower;

  tlr_fq_if #(.N(NUM_CH)) fq ();

  // Decode and next value per limit register
  for (genvar i = 0; i < NUM_LIM; i++) begin : g_lim
    assign wr_hit[i] = wr_in && (cmd_in == LIM_CMD[i]);
    assign rd_hit[i] = rd_in && (cmd_in == LIM_CMD[i]);

    always_comb begin
      lim_d[i] = lim_q[i];
      if (wr_hit[i]) begin
        lim_d[i] = wdata_in & LIM_MASK[i];
      end
    end

    always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
        lim_q[i] <= LIM_RST[i];
      end else begin
        lim_q[i] <= lim_d[i];
      end
    end
  end

  // Any write to a limit purges the queue of the limit it sets
  always_comb begin
    flush = '0;
    for (int i = 0; i < NUM_LIM; i++) begin
      if (wr_hit[i]) begin
        flush[LIM_CH[i]] = 1'b1;
      end
    end
  end

  // Read mux; unmapped commands read as zero
  always_comb begin
    rdata_d    = RD_NONE;
    rd_valid_d = rd_in;
    for (int i = 0; i < NUM_LIM; i++) begin
      if (rd_hit[i]) begin
        rdata_d = lim_q[i];
      end
    end
  end

  // Read answer registered, valid for one cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_q    <= RD_NONE;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rdata_out    = rdata_q;
  assign rd_valid_out = rd_valid_q;

  // Signed compares; remote uses integer plus top fraction nibble
  assign remote_temp  = signed'(remote_temp_in);
  assign remote_upper = signed'({lim_q[LIM_RU], lim_q[LIM_RUF][7:4]});
  assign remote_lower = signed'({lim_q[LIM_RL], lim_q[LIM_RLF][7:4]});

  assign fq.flush     = flush;
  assign fq.sample    = conv_done_in;
  assign fq.depth_sel = queue_depth_select_in;
  assign fq.exceed[CH_LOCAL_HIGH] =
    signed'(local_temp_in) > signed'(lim_q[LIM_LU]);
  assign fq.exceed[CH_LOCAL_LOW] =
    signed'(local_temp_in) < signed'(lim_q[LIM_LL]);
  assign fq.exceed[CH_REMOTE_HIGH] = remote_temp > remote_upper;
  assign fq.exceed[CH_REMOTE_LOW]  = remote_temp < remote_lower;

  // Queue events leave straight from the queue's flip-flops
  tlr_fault_queue #(.N(NUM_CH)) u_queue (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .fq      (fq)
  );

  assign local_high_event_out  = fq.event_hit[CH_LOCAL_HIGH];
  assign local_low_event_out   = fq.event_hit[CH_LOCAL_LOW];
  assign remote_high_event_out = fq.event_hit[CH_REMOTE_HIGH];
  assign remote_low_event_out  = fq.event_hit[CH_REMOTE_LOW];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_write_local_upper;
    wr_in && cmd_in == CMD_LOCAL_UPPER;
  endsequence

  sequence s_read_local_upper;
    rd_in && !wr_in && cmd_in == CMD_LOCAL_UPPER;
  endsequence

  // Reset values checked in the first cycle after release
  a_reset_local_upper: assert property ($past(!rstn_in) |->
    lim_q[LIM_LU] == RST_LOCAL_UPPER && lim_q[LIM_LL] == RST_LOCAL_LOWER)
    else $error("local limits wrong after reset");
  a_reset_remote_int: assert property ($past(!rstn_in) |->
    lim_q[LIM_RU] == RST_REMOTE_UPPER && lim_q[LIM_RL] == RST_REMOTE_LOWER)
    else $error("remote limits wrong after reset");
  // Host leaves one idle cycle between a write and the next read
  a_write_then_read: assert property (
    s_write_local_upper ##1 !wr_in ##1 s_read_local_upper |=>
    rd_valid_out && rdata_out == $past(wdata_in, 3))
    else $error("local upper limit did not read back");
  a_write_low_int: assert property (wr_in && cmd_in == CMD_REMOTE_LOWER |=>
    lim_q[LIM_RL] == $past(wdata_in))
    else $error("remote lower limit not written");
  a_write_local_low: assert property (wr_in && cmd_in == CMD_LOCAL_LOWER |=>
    lim_q[LIM_LL] == $past(wdata_in))
    else $error("local lower limit not written");
  a_frac_low_zero: assert property (
    lim_q[LIM_RUF][3:0] == 4'h0 && lim_q[LIM_RLF][3:0] == 4'h0)
    else $error("fraction low bits not zero");
  a_flush_on_write: assert property (s_write_local_upper |=>
    !local_high_event_out)
    else $error("event after limit write");
  a_read_unmapped: assert property (rd_in && cmd_in == 8'h09 |=>
    rd_valid_out && rdata_out == RD_NONE)
    else $error("unmapped read not zero");
  // Fresh streak at depth one: a reading below a signed limit fires at once
  a_signed_compare: assert property (conv_done_in &&
    !flush[CH_LOCAL_LOW] && queue_depth_select_in == DSEL_1 &&
    u_queue.g_ch[CH_LOCAL_LOW].cnt_q == CNT_RST &&
    $signed(local_temp_in) < $signed(lim_q[LIM_LL])
    |=> local_low_event_out)
    else $error("negative reading not below zero limit");
endmodule

// file: tlr_pkg.sv
// Functional notes
// - Local upper limit, command 05h, resets to 3Ch (60 degrees), read/write.
// - Local lower limit, command 06h, resets to 00h (0 degrees), read/write.
// - Remote upper limit integer byte, command 07h, resets to 50h (80 degrees).
// - Remote lower limit integer byte, command 08h, resets to 00h.
// - Limits are signed two's complement, one degree per bit.
// - Any completed limit write flushes that limit's fault queue.
// - Remote fraction bytes hold sixteenths in bits 7:4; bits 3:0 read zero.
// - Two-bit depth select gives queue depths of 1, 2, 4 or 6.
package tlr_pkg;
  localparam int NUM_CH  = 4;
  localparam int NUM_LIM = 6;
  localparam int CNT_W   = 3;

  // Channel order of the fault queues
  localparam int CH_LOCAL_HIGH  = 0;
  localparam int CH_LOCAL_LOW   = 1;
  localparam int CH_REMOTE_HIGH = 2;
  localparam int CH_REMOTE_LOW  = 3;

  // Limit register slots
  localparam int LIM_LU = 0;
  localparam int LIM_LL = 1;
  localparam int LIM_RU = 2;
  localparam int LIM_RL = 3;
  localparam int LIM_RUF = 4;
  localparam int LIM_RLF = 5;

  localparam logic [7:0] CMD_LOCAL_UPPER  = 8'h05;
  localparam logic [7:0] CMD_LOCAL_LOWER  = 8'h06;
  localparam logic [7:0] CMD_REMOTE_UPPER = 8'h07;
  localparam logic [7:0] CMD_REMOTE_LOWER = 8'h08;
  localparam logic [7:0] CMD_REMOTE_UPPER_FRAC = 8'h13;
  localparam logic [7:0] CMD_REMOTE_LOWER_FRAC = 8'h14;

  localparam logic [7:0] RST_LOCAL_UPPER  = 8'h3c;
  localparam logic [7:0] RST_LOCAL_LOWER  = 8'h00;
  localparam logic [7:0] RST_REMOTE_UPPER = 8'h50;
  localparam logic [7:0] RST_REMOTE_LOWER = 8'h00;
  localparam logic [7:0] RST_FRAC         = 8'h00;

  localparam logic [7:0] MASK_INT  = 8'hff;
  localparam logic [7:0] MASK_FRAC = 8'hf0;
  localparam logic [7:0] RD_NONE   = 8'h00;

  localparam logic [7:0] LIM_CMD [NUM_LIM] = '{CMD_LOCAL_UPPER,
    CMD_LOCAL_LOWER, CMD_REMOTE_UPPER, CMD_REMOTE_LOWER,
    CMD_REMOTE_UPPER_FRAC, CMD_REMOTE_LOWER_FRAC};
  localparam logic [7:0] LIM_RST [NUM_LIM] = '{RST_LOCAL_UPPER,
    RST_LOCAL_LOWER, RST_REMOTE_UPPER, RST_REMOTE_LOWER,
    RST_FRAC, RST_FRAC};
  localparam logic [7:0] LIM_MASK [NUM_LIM] = '{MASK_INT, MASK_INT,
    MASK_INT, MASK_INT, MASK_FRAC, MASK_FRAC};
  localparam int LIM_CH [NUM_LIM] = '{CH_LOCAL_HIGH, CH_LOCAL_LOW,
    CH_REMOTE_HIGH, CH_REMOTE_LOW, CH_REMOTE_HIGH, CH_REMOTE_LOW};

  // Queue depth encodings
  localparam logic [1:0]       DSEL_1  = 2'h0;
  localparam logic [1:0]       DSEL_2  = 2'h1;
  localparam logic [1:0]       DSEL_4  = 2'h2;
  localparam logic [1:0]       DSEL_6  = 2'h3;
  localparam logic [CNT_W-1:0] DEPTH_1 = 3'h1;
  localparam logic [CNT_W-1:0] DEPTH_2 = 3'h2;
  localparam logic [CNT_W-1:0] DEPTH_4 = 3'h4;
  localparam logic [CNT_W-1:0] DEPTH_6 = 3'h6;
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
endpackage
